// ===== design/drm_route_mask_cfg.sv
// default route register, multicast mask command register and default-route forwarding decision
// Summary of operation
// - miss packets go to default port field
// - default port field resets to unmapped 0xFF
// - default above port total means unmapped
// - unmapped default route discards the packet
// - mask number selects mask to modify
// - query setup selects mask reported on read
// - mask and port fields read back written
// - four masks, mask number top bit zero
// - egress port byte names single port
// - egress port ignored for all-port commands
// - eight ports, egress number top bit zero
// - edits accepted regardless of table binding
// - command codes add or remove one port
// - query setup changes no mask bit
// - clear removes all, fill adds all
// - present bit shows queried port membership
`default_nettype none
module drm_route_mask_cfg
   import drm_pkg::*;
#(
   parameter int NUM_MASKS = 4,
   parameter int NUM_PORTS = 8
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   input wire logic [7:0] port_total,
   input wire logic pkt_valid,
   input wire logic pkt_lut_hit,
   input wire logic [7:0] pkt_lut_port,
   output logic route_valid,
   output logic [7:0] route_port,
   output logic route_discard,
   output logic [NUM_MASKS*NUM_PORTS-1:0] mcast_masks
);

   generate
      if (NUM_MASKS < 1 || NUM_MASKS > 4 || NUM_PORTS < 1 || NUM_PORTS > 8) begin : g_bad_params
         $error("drm_route_mask_cfg: NUM_MASKS must be 1..4 and NUM_PORTS 1..8");
      end
   endgenerate

   logic [7:0] default_port_reg;
   logic [15:0] mask_select_reg;
   logic [7:0] egress_select_reg;
   logic [2:0] cmd_reg;
   logic [NUM_PORTS-1:0] mask_reg [NUM_MASKS];
   logic [31:0] rdata_reg;
   logic route_valid_reg;
   logic [7:0] route_port_reg;
   logic route_discard_reg;

   logic wr_default;
   logic wr_cmd;
   logic [15:0] wr_mask_sel;
   logic [7:0] wr_egress_sel;
   logic [2:0] wr_code;
   logic wr_mask_ok;
   logic wr_port_ok;
   logic default_unmapped;
   logic query_present;

   assign wr_default = reg_write && (reg_addr == DRM_OFS_DEFAULT_ROUTE_PORT);
   assign wr_cmd = reg_write && (reg_addr == DRM_OFS_MCAST_MASK_CMD);

   // top bit of the mask select and egress select ranges is held at zero; the command code is not
   always_comb begin
      wr_mask_sel = reg_wdata[DRM_MASK_SELECT_LSB +: 16];
      wr_mask_sel[DRM_MASK_SELECT_TOP_BIT] = 1'b0;
      wr_egress_sel = reg_wdata[DRM_EGRESS_SELECT_LSB +: 8];
      wr_egress_sel[DRM_EGRESS_SELECT_TOP_BIT] = 1'b0;
      wr_code = reg_wdata[DRM_CMD_LSB +: 3];
   end

   assign wr_mask_ok = (wr_mask_sel < 16'(NUM_MASKS));
   assign wr_port_ok = (wr_egress_sel < 8'(NUM_PORTS));

   // default route port field
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         default_port_reg <= DRM_DEFAULT_PORT_RESET;
      end else if (wr_default) begin
         default_port_reg <= reg_wdata[DRM_DEFAULT_PORT_LSB +: 8];
      end
   end

   // command register fields kept for read back and query
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         mask_select_reg <= DRM_MCAST_CMD_RESET[DRM_MASK_SELECT_LSB +: 16];
         egress_select_reg <= DRM_MCAST_CMD_RESET[DRM_EGRESS_SELECT_LSB +: 8];
         cmd_reg <= DRM_MCAST_CMD_RESET[DRM_CMD_LSB +: 3];
      end else if (wr_cmd) begin
         mask_select_reg <= wr_mask_sel;
         egress_select_reg <= wr_egress_sel;
         cmd_reg <= wr_code;
      end
   end

   // mask contents; no dependence on group table binding
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         for (int m = 0; m < NUM_MASKS; m++) begin
            mask_reg[m] <= '0;
         end
      end else if (wr_cmd && wr_mask_ok) begin
         case (wr_code)
            DRM_CMD_ADD_PORT: begin
               if (wr_port_ok) begin
                  mask_reg[wr_mask_sel[1:0]][wr_egress_sel[2:0]] <= 1'b1;
               end
            end
            DRM_CMD_DEL_PORT: begin
               if (wr_port_ok) begin
                  mask_reg[wr_mask_sel[1:0]][wr_egress_sel[2:0]] <= 1'b0;
               end
            end
            DRM_CMD_DEL_ALL: begin
               mask_reg[wr_mask_sel[1:0]] <= '0;
            end
            DRM_CMD_ADD_ALL: begin
               mask_reg[wr_mask_sel[1:0]] <= '1;
            end
            default: begin
               // query setup and reserved codes leave masks alone
               mask_reg[wr_mask_sel[1:0]] <= mask_reg[wr_mask_sel[1:0]];
            end
         endcase
      end
   end

   always_comb begin
      for (int m = 0; m < NUM_MASKS; m++) begin
         mcast_masks[m*NUM_PORTS +: NUM_PORTS] = mask_reg[m];
      end
   end

   // membership of the last specified port in the last specified mask
   always_comb begin
      query_present = 1'b0;
      if (mask_select_reg < 16'(NUM_MASKS) && egress_select_reg < 8'(NUM_PORTS)) begin
         query_present = mask_reg[mask_select_reg[1:0]][egress_select_reg[2:0]];
      end
   end

   // read data one cycle after the strobe
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rdata_reg <= 32'h00000000;
      end else if (reg_read) begin
         rdata_reg <= 32'h00000000;
         case (reg_addr)
            DRM_OFS_DEFAULT_ROUTE_PORT: begin
               rdata_reg[DRM_DEFAULT_PORT_LSB +: 8] <= default_port_reg;
            end
            DRM_OFS_MCAST_MASK_CMD: begin
               rdata_reg[DRM_MASK_SELECT_LSB +: 16] <= mask_select_reg;
               rdata_reg[DRM_EGRESS_SELECT_LSB +: 8] <= egress_select_reg;
               rdata_reg[DRM_CMD_LSB +: 3] <= cmd_reg;
               rdata_reg[DRM_PRESENT_BIT] <= query_present;
            end
            default: begin
               rdata_reg <= 32'h00000000;
            end
         endcase
      end else begin
         rdata_reg <= 32'h00000000;
      end
   end

   assign reg_rdata = rdata_reg;

   assign default_unmapped = (default_port_reg > port_total);

   // forwarding decision, one cycle after the packet request
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         route_valid_reg <= 1'b0;
         route_port_reg <= 8'h00;
         route_discard_reg <= 1'b0;
      end else begin
         route_valid_reg <= pkt_valid;
         route_port_reg <= 8'h00;
         route_discard_reg <= 1'b0;
         if (pkt_valid) begin
            if (pkt_lut_hit) begin
               route_port_reg <= pkt_lut_port;
            end else if (default_unmapped) begin
               route_discard_reg <= 1'b1;
            end else begin
               route_port_reg <= default_port_reg;
            end
         end
      end
   end

   assign route_valid = route_valid_reg;
   assign route_port = route_port_reg;
   assign route_discard = route_discard_reg;

endmodule : drm_route_mask_cfg
`default_nettype wire

// ===== pkg/drm_pkg.sv
// register map and field layout for default route and multicast mask configuration
`default_nettype none
package drm_pkg;
   localparam logic [7:0] DRM_OFS_DEFAULT_ROUTE_PORT = 8'h78;
   localparam logic [7:0] DRM_OFS_MCAST_MASK_CMD = 8'h80;
   localparam logic [7:0] DRM_DEFAULT_PORT_RESET = 8'hFF;
   localparam logic [31:0] DRM_MCAST_CMD_RESET = 32'h00000000;
   localparam int DRM_DEFAULT_PORT_LSB = 0;
   localparam int DRM_MASK_SELECT_LSB = 16;
   localparam int DRM_EGRESS_SELECT_LSB = 8;
   localparam int DRM_CMD_LSB = 4;
   localparam int DRM_PRESENT_BIT = 0;
   localparam int DRM_MASK_SELECT_TOP_BIT = 2;
   localparam int DRM_EGRESS_SELECT_TOP_BIT = 3;
   typedef enum logic [2:0] {
      DRM_CMD_QUERY_SETUP = 3'b000,
      DRM_CMD_ADD_PORT = 3'b001,
      DRM_CMD_DEL_PORT = 3'b010,
      DRM_CMD_DEL_ALL = 3'b100,
      DRM_CMD_ADD_ALL = 3'b101
   } drm_cmd_e;
endpackage : drm_pkg
`default_nettype wire

// ===== verif/drm_checker.sv
// port assertions for default route and multicast mask configuration
`default_nettype none
module drm_checker (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [31:0] reg_rdata,
   input wire logic [7:0] port_total,
   input wire logic pkt_valid,
   input wire logic pkt_lut_hit,
   input wire logic [7:0] pkt_lut_port,
   input wire logic route_valid,
   input wire logic [7:0] route_port,
   input wire logic route_discard
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] dflt_reg;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   // shadow of the default port field
   always_ff @(posedge clk_sys) begin
      if (rst)
         dflt_reg <= 8'hFF;
      else if (reg_write && reg_addr == 8'h78)
         dflt_reg <= reg_wdata[7:0];
   end
   a_route_pulse: assert property (pkt_valid |=> route_valid)
      else $error("route answer missing");
   a_hit_port: assert property (pkt_valid && pkt_lut_hit |=> route_port == $past(pkt_lut_port) && !route_discard)
      else $error("lookup hit port wrong");
   a_default_fwd: assert property (pkt_valid && !pkt_lut_hit && dflt_reg <= port_total
      |=> route_port == $past(dflt_reg) && !route_discard) else $error("default route not taken");
   a_unmapped_drop: assert property (pkt_valid && !pkt_lut_hit && dflt_reg > port_total
      |=> route_discard && route_port == 8'h00) else $error("unmapped route not dropped");
   a_idle_route: assert property (!route_valid |-> route_port == 8'h00 && !route_discard)
      else $error("route outputs active when idle");
   a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
      else $error("read data outside read cycle");
   a_dflt_read: assert property (reg_read && reg_addr == 8'h78 |=> reg_rdata == {24'h0, $past(dflt_reg)})
      else $error("default route readback wrong");
   a_mask_read: assert property (reg_read && reg_addr == 8'h80
      |=> !reg_rdata[18] && !reg_rdata[11] && !reg_rdata[7] && reg_rdata[3:1] == 3'h0) else $error("forced zero bit set");
endmodule : drm_checker
bind drm_route_mask_cfg drm_checker u_chk (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .port_total(port_total), .pkt_valid(pkt_valid),
   .pkt_lut_hit(pkt_lut_hit), .pkt_lut_port(pkt_lut_port), .route_valid(route_valid), .route_port(route_port),
   .route_discard(route_discard));
`default_nettype wire

// ===== verif/default_route_and_multicast_mask_cfg_bench.sv
// self-checking bench for default route and multicast mask configuration
`default_nettype none
module default_route_and_multicast_mask_cfg_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 0, rst = 1, reg_write = 0, reg_read = 0, pkt_valid = 0, pkt_lut_hit = 0;
   logic [7:0] reg_addr = 0, port_total = 8'h08, pkt_lut_port = 0, route_port;
   logic [31:0] reg_wdata = 0, reg_rdata, mcast_masks;
   logic route_valid, route_discard;
   int errors = 0, compares = 0;
   logic [2:0] cmds [7] = '{3'h5, 3'h2, 3'h0, 3'h1, 3'h3, 3'h4, 3'h1};
   logic [7:0] ports [7] = '{8'h2, 8'h2, 8'h2, 8'h2, 8'h2, 8'h2, 8'h3};
   logic [7:0] exps [7] = '{8'hFF, 8'hFB, 8'hFB, 8'hFF, 8'hFF, 8'h00, 8'h08};
   drm_route_mask_cfg u_dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .port_total(port_total),
      .pkt_valid(pkt_valid), .pkt_lut_hit(pkt_lut_hit), .pkt_lut_port(pkt_lut_port), .route_valid(route_valid),
      .route_port(route_port), .route_discard(route_discard), .mcast_masks(mcast_masks));
   initial forever #4 clk_sys = ~clk_sys;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_write <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk_sys);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_read <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask : rd
   // one packet; expected {valid, discard, port}
   task automatic pk(input logic hit, input logic [7:0] lp, input logic [9:0] e);
      @(posedge clk_sys);
      pkt_valid <= 1'b1;
      pkt_lut_hit <= hit;
      pkt_lut_port <= lp;
      @(posedge clk_sys);
      pkt_valid <= 1'b0;
      #1 chk({22'h0, route_valid, route_discard, route_port}, {22'h0, e});
   endtask : pk
   task automatic results;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : results
   initial begin
      #20000;
      errors++;
      results;
   end
   initial begin
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      rd(8'h78, 32'hFF);
      rd(8'h80, 32'h0);
      pk(1'b0, 8'h01, 10'h300);
      pk(1'b1, 8'h03, 10'h203);
      wr(8'h78, 32'hFFFFFF05);
      rd(8'h78, 32'h05);
      pk(1'b0, 8'h03, 10'h205);
      wr(8'h78, 32'h08);
      pk(1'b0, 8'h03, 10'h208);
      wr(8'h78, 32'h09);
      pk(1'b0, 8'h03, 10'h300);
      wr(8'h78, 32'hFF);
      pk(1'b0, 8'h03, 10'h300);
      wr(8'h84, 32'hFFFFFFFF);
      rd(8'h84, 32'h0);
      wr(8'h80, 32'h00070F0F);
      rd(8'h80, 32'h00030700);
      // walk every command on mask 1, other masks stay empty
      for (int i = 0; i < 7; i++) begin
         wr(8'h80, {16'h1, ports[i], 1'b0, cmds[i], 4'h0});
         #1 chk(mcast_masks, {16'h0, exps[i], 8'h0});
         rd(8'h80, {16'h1, ports[i], 1'b0, cmds[i], 3'h0, exps[i][ports[i][2:0]]});
      end
      results;
   end
endmodule : default_route_and_multicast_mask_cfg_bench
`default_nettype wire
